// ### logic/tsr_pkg.sv
// Constants and carrier types shared by the TDM slot path router.
// Assumes a 32-bit classic Wishbone register bus and a serial bit clock link.
package tsr_pkg;

  // Register byte offsets
  localparam logic [7:0] TSR_OFS_DSEL = 8'h00;
  localparam logic [7:0] TSR_OFS_CTRL = 8'h04;
  localparam logic [7:0] TSR_OFS_MASK = 8'h08;
  localparam logic [7:0] TSR_OFS_STAT = 8'h0C;
  localparam logic [7:0] TSR_OFS_TRK = 8'h10;

  // Field positions
  localparam int TSR_DSEL_MAIN_LSB = 0;
  localparam int TSR_DSEL_LL_LSB = 4;
  localparam int TSR_CTRL_TRK_LSB = 0;
  localparam int TSR_CTRL_TDM_BIT = 4;
  localparam int TSR_CTRL_I2S_BIT = 5;
  localparam int TSR_MASK_LINE2_LSB = 16;

  // Writable bits and reset values
  localparam logic [31:0] TSR_DSEL_WMASK = 32'h0000_0077;
  localparam logic [31:0] TSR_CTRL_WMASK = 32'h0000_0037;
  localparam logic [31:0] TSR_MASK_WMASK = 32'hFFFF_FFFF;
  localparam logic [31:0] TSR_DSEL_RST = 32'h0000_0040;
  localparam logic [31:0] TSR_CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] TSR_MASK_RST = 32'hFFFF_FFFF;

  // Frame geometry
  localparam logic [4:0] TSR_SLOT_LAST_BIT = 5'h1F;
  localparam logic [3:0] TSR_TDM_LAST_SLOT = 4'hF;
  localparam logic [3:0] TSR_PCM_LAST_SLOT = 4'h1;
  localparam logic [2:0] TSR_TRK_MASKED = 3'h4;

  // Routing settings as seen by the link logic
  typedef struct packed {
    logic tdm;
    logic i2s;
    logic [2:0] main_path_slot_select;
    logic [2:0] low_latency_slot_select;
    logic [2:0] tracking_path_slot_select;
    logic [15:0] mask1;
    logic [15:0] mask2;
  } tsr_cfg_s;

  // One routed frame of samples for the three output paths
  typedef struct packed {
    logic [3:0][23:0] main_audio_converters;
    logic [3:0][23:0] low_latency_path;
    logic [23:0] tracking_converter;
  } tsr_frame_s;

  typedef enum logic {
    LK_IDLE,
    LK_SLOT
  } tsr_lk_e;

endpackage

// ### logic/tsr_word_cross.sv
// Toggle handshake that carries one word from a source clock to a destination clock.
// Assumes each side has its own synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tsr_word_cross #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_load,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);

  typedef struct packed {
    logic req;
    logic a1;
    logic a2;
    logic [W-1:0] data;
  } tsr_src_s;

  typedef struct packed {
    logic r1;
    logic r2;
    logic ack;
    logic vld;
    logic [W-1:0] data;
  } tsr_dst_s;

  tsr_src_s s_reg, s_next;
  tsr_dst_s d_reg, d_next;

  // Source holds its word steady until the far side has echoed the toggle
  assign src_busy = s_reg.req ^ s_reg.a2;

  always_comb begin
    s_next = s_reg;
    s_next.a1 = d_reg.ack;
    s_next.a2 = s_reg.a1;
    if (!src_rst_n) begin
      s_next = '0;
    end else if (src_load && !src_busy) begin
      s_next.req = ~s_reg.req;
      s_next.data = src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    s_reg <= s_next;
  end

  // Destination takes the word only once the toggle has passed two flops
  always_comb begin
    d_next = d_reg;
    d_next.r1 = s_reg.req;
    d_next.r2 = d_reg.r1;
    d_next.vld = 1'b0;
    if (!dst_rst_n) begin
      d_next = '0;
    end else if (d_reg.r2 != d_reg.ack) begin
      d_next.ack = d_reg.r2;
      d_next.data = s_reg.data;
      d_next.vld = 1'b1;
    end
  end

  always_ff @(posedge dst_clk) begin
    d_reg <= d_next;
  end

  assign dst_valid = d_reg.vld;
  assign dst_data = d_reg.data;

endmodule
`default_nettype wire

// ### logic/tsr_router.sv
// TDM slot path router: picks serial slots for the main, low-latency and tracking paths.
// Assumes a classic Wishbone master on clk and a host driving link_clk and frame_sync.
//
// What this block does
// - Each output path has its own source select
// - Tracking select is 3 bits in control register
// - Main select picks four-slot group and line
// - Low-latency select uses the same encoding
// - Tracking codes 0-3 use three slots' low bytes
// - Code 100 uses mask bits; 101-111 reserved
// - Mask bit zero admits its slot
// - Stereo formats use fixed routing, selects ignored
// - Tracking output holds its last word in stereo formats
// - Every slot is 32 bit clocks wide
`timescale 1ns/1ps
`default_nettype none
module tsr_router
  import tsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk,
  input wire logic frame_sync,
  input wire logic first_serial_input,
  input wire logic second_serial_input,
  output tsr_frame_s samples,
  output logic sample_valid
);

  // Byte-lane merge of a register write
  function automatic logic [31:0] wr_merge(
    input logic [31:0] old,
    input logic [31:0] din,
    input logic [3:0] sel,
    input logic [31:0] wmask
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = din[8*i +: 8];
      end
    end
    return res & wmask;
  endfunction

  // Audio part of the slot from the line that a select code names
  function automatic logic [23:0] pick_line(
    input logic line2,
    input logic [31:0] w1,
    input logic [31:0] w2
  );
    return line2 ? w2[31:8] : w1[31:8];
  endfunction

  // Bus-side state
  typedef struct packed {
    logic [31:0] dsel;
    logic [31:0] ctrl;
    logic [31:0] mask;
    logic ack;
    logic [31:0] dat;
    logic [15:0] frames;
    logic vld;
    tsr_frame_s out;
  } tsr_bus_s;

  // Link-side state
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic fs_d;
    logic edge_d;
    tsr_lk_e st;
    logic [4:0] bitc;
    logic [3:0] slot;
    logic [31:0] sh1;
    logic [31:0] sh2;
    logic taken;
    tsr_cfg_s cfg;
    tsr_frame_s fr;
  } tsr_link_s;

  tsr_bus_s b_reg, b_next;
  tsr_link_s l_reg, l_next;

  tsr_cfg_s cfg_bus;
  tsr_cfg_s cfg_link;
  logic cfg_link_vld;
  tsr_frame_s fr_bus;
  logic fr_bus_vld;
  logic fr_load;
  logic wb_req;

  // Routing settings gathered from the register words
  always_comb begin
    cfg_bus.main_path_slot_select = b_reg.dsel[TSR_DSEL_MAIN_LSB +: 3];
    cfg_bus.low_latency_slot_select = b_reg.dsel[TSR_DSEL_LL_LSB +: 3];
    cfg_bus.tracking_path_slot_select = b_reg.ctrl[TSR_CTRL_TRK_LSB +: 3];
    cfg_bus.tdm = b_reg.ctrl[TSR_CTRL_TDM_BIT];
    cfg_bus.i2s = b_reg.ctrl[TSR_CTRL_I2S_BIT];
    cfg_bus.mask1 = b_reg.mask[15:0];
    cfg_bus.mask2 = b_reg.mask[TSR_MASK_LINE2_LSB +: 16];
  end

  // Settings are resent whenever the crossing is idle, so link sees changes within a few edges
  tsr_word_cross #(
    .W($bits(tsr_cfg_s))
  ) u_cfg_cross (
    .src_clk(clk),
    .src_rst_n(rst_n),
    .src_load(1'b1),
    .src_data(cfg_bus),
    .src_busy(),
    .dst_clk(link_clk),
    .dst_rst_n(l_reg.rs2),
    .dst_valid(cfg_link_vld),
    .dst_data(cfg_link)
  );

  // Completed frames travel back to the bus clock
  tsr_word_cross #(
    .W($bits(tsr_frame_s))
  ) u_frame_cross (
    .src_clk(link_clk),
    .src_rst_n(l_reg.rs2),
    .src_load(fr_load),
    .src_data(l_next.fr),
    .src_busy(),
    .dst_clk(clk),
    .dst_rst_n(rst_n),
    .dst_valid(fr_bus_vld),
    .dst_data(fr_bus)
  );

  assign wb_req = wb_cyc_i & wb_stb_i & ~b_reg.ack;

  // Wishbone slave: one wait state, unmapped addresses ack with zero data
  always_comb begin
    b_next = b_reg;
    b_next.ack = wb_req;
    b_next.vld = 1'b0;
    if (fr_bus_vld) begin
      b_next.out = fr_bus;
      b_next.vld = 1'b1;
      b_next.frames = b_reg.frames + 16'h0001;
    end
    if (wb_req && wb_we_i) begin
      if (wb_adr_i == TSR_OFS_DSEL) begin
        b_next.dsel = wr_merge(b_reg.dsel, wb_dat_i, wb_sel_i, TSR_DSEL_WMASK);
      end else if (wb_adr_i == TSR_OFS_CTRL) begin
        b_next.ctrl = wr_merge(b_reg.ctrl, wb_dat_i, wb_sel_i, TSR_CTRL_WMASK);
      end else if (wb_adr_i == TSR_OFS_MASK) begin
        b_next.mask = wr_merge(b_reg.mask, wb_dat_i, wb_sel_i, TSR_MASK_WMASK);
      end
    end
    if (wb_req) begin
      if (wb_adr_i == TSR_OFS_DSEL) begin
        b_next.dat = b_reg.dsel;
      end else if (wb_adr_i == TSR_OFS_CTRL) begin
        b_next.dat = b_reg.ctrl;
      end else if (wb_adr_i == TSR_OFS_MASK) begin
        b_next.dat = b_reg.mask;
      end else if (wb_adr_i == TSR_OFS_STAT) begin
        b_next.dat = {16'h0000, b_reg.frames};
      end else if (wb_adr_i == TSR_OFS_TRK) begin
        b_next.dat = {8'h00, b_reg.out.tracking_converter};
      end else begin
        b_next.dat = 32'h0000_0000;
      end
    end
    if (!rst_n) begin
      b_next = '0;
      b_next.dsel = TSR_DSEL_RST;
      b_next.ctrl = TSR_CTRL_RST;
      b_next.mask = TSR_MASK_RST;
    end
  end

  always_ff @(posedge clk) begin
    b_reg <= b_next;
  end

  assign wb_ack_o = b_reg.ack;
  assign wb_dat_o = b_reg.dat;
  assign samples = b_reg.out;
  assign sample_valid = b_reg.vld;

  // Link-side slot framing and path extraction
  always_comb begin
    logic fs_edge;
    logic start;
    logic left;
    logic done;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [3:0] s;
    logic [2:0] tc;
    fs_edge = 1'b0;
    start = 1'b0;
    left = 1'b0;
    done = 1'b0;
    w1 = {l_reg.sh1[30:0], first_serial_input};
    w2 = {l_reg.sh2[30:0], second_serial_input};
    s = l_reg.slot;
    tc = l_reg.cfg.tracking_path_slot_select;
    fr_load = 1'b0;
    l_next = l_reg;
    l_next.rs1 = rst_n;
    l_next.rs2 = l_reg.rs1;
    l_next.fs_d = frame_sync;
    if (cfg_link_vld) begin
      l_next.cfg = cfg_link;
    end
    // TDM frames open on a rising sync; stereo formats open a slot on either edge
    if (l_reg.cfg.tdm) begin
      fs_edge = frame_sync & ~l_reg.fs_d;
    end else begin
      fs_edge = frame_sync ^ l_reg.fs_d;
    end
    l_next.edge_d = fs_edge;
    // I2S data lags the sync edge by one bit clock
    start = (!l_reg.cfg.tdm && l_reg.cfg.i2s) ? l_reg.edge_d : fs_edge;
    left = l_reg.cfg.i2s ? ~frame_sync : frame_sync;
    if (start) begin
      l_next.st = LK_SLOT;
      l_next.bitc = 5'h01;
      l_next.sh1 = w1;
      l_next.sh2 = w2;
      l_next.taken = 1'b0;
      if (l_reg.cfg.tdm) begin
        l_next.slot = 4'h0;
      end else begin
        l_next.slot = left ? 4'h0 : 4'h1;
      end
    end else if (l_reg.st == LK_SLOT) begin
      l_next.sh1 = w1;
      l_next.sh2 = w2;
      l_next.bitc = l_reg.bitc + 5'h01;
      done = (l_reg.bitc == TSR_SLOT_LAST_BIT);
    end
    if (done) begin
      l_next.slot = s + 4'h1;
      if (l_reg.cfg.tdm) begin
        // Four-slot groups for the two audio paths
        if (s[3:2] == l_reg.cfg.main_path_slot_select[1:0]) begin
          l_next.fr.main_audio_converters[s[1:0]] =
            pick_line(l_reg.cfg.main_path_slot_select[2], w1, w2);
        end
        if (s[3:2] == l_reg.cfg.low_latency_slot_select[1:0]) begin
          l_next.fr.low_latency_path[s[1:0]] =
            pick_line(l_reg.cfg.low_latency_slot_select[2], w1, w2);
        end
        // Tracking word built from the low bytes of three first-line slots
        if (!tc[2] && s[3:2] == tc[1:0]) begin
          case (s[1:0])
            2'h0: l_next.fr.tracking_converter[23:16] = w1[7:0];
            2'h1: l_next.fr.tracking_converter[15:8] = w1[7:0];
            2'h2: l_next.fr.tracking_converter[7:0] = w1[7:0];
            default: l_next.fr.tracking_converter = l_reg.fr.tracking_converter;
          endcase
        end else if (tc == TSR_TRK_MASKED && !l_reg.taken) begin
          // First unmasked slot of the frame wins; first line before second
          if (!l_reg.cfg.mask1[s]) begin
            l_next.fr.tracking_converter = w1[31:8];
            l_next.taken = 1'b1;
          end else if (!l_reg.cfg.mask2[s]) begin
            l_next.fr.tracking_converter = w2[31:8];
            l_next.taken = 1'b1;
          end
        end
        // Reserved tracking codes leave the last tracking word in place
        if (s == TSR_TDM_LAST_SLOT) begin
          l_next.st = LK_IDLE;
          fr_load = 1'b1;
        end
      end else begin
        // Fixed stereo routing: first line to converters 1-2, second to 3-4
        l_next.fr.main_audio_converters[{1'b0, s[0]}] = w1[31:8];
        l_next.fr.main_audio_converters[{1'b1, s[0]}] = w2[31:8];
        // Tracking word is not refreshed here but still drives out
        l_next.st = LK_IDLE;
        fr_load = (s == TSR_PCM_LAST_SLOT);
      end
    end
    if (!l_reg.rs2) begin
      l_next = '0;
      l_next.rs1 = rst_n;
      l_next.rs2 = l_reg.rs1;
      l_next.fs_d = frame_sync;
      l_next.st = LK_IDLE;
      l_next.cfg.tdm = TSR_CTRL_RST[TSR_CTRL_TDM_BIT];
      l_next.cfg.mask1 = TSR_MASK_RST[15:0];
      l_next.cfg.mask2 = TSR_MASK_RST[TSR_MASK_LINE2_LSB +: 16];
    end
  end

  // Link-side register; reset arrives through the two-flop stage above
  always_ff @(posedge link_clk) begin
    l_reg <= l_next;
  end

endmodule
`default_nettype wire

// ### bench/tsr_router_props.sv
// Checker for the slot router: bus handshake, register spares and frame delivery.
// Assumes it is bound to tsr_router and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tsr_router_props
  import tsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic link_clk,
  input wire logic frame_sync,
  input wire tsr_frame_s samples,
  input wire logic sample_valid
);
  logic fs_reg;
  logic [7:0] quiet_reg;
  // Link edges since sync last moved; a delivered frame ends at least a slot later
  always_ff @(posedge link_clk) begin
    fs_reg <= frame_sync;
    if (!rst_n || frame_sync != fs_reg) begin
      quiet_reg <= 8'h00;
    end else if (quiet_reg != 8'hFF) begin
      quiet_reg <= quiet_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h10
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_dsel_spare_zero: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == TSR_OFS_DSEL
    |-> (wb_dat_o & ~TSR_DSEL_WMASK) == 32'h0) else $error("select spare bits set");
  a_ctrl_spare_zero: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == TSR_OFS_CTRL
    |-> (wb_dat_o & ~TSR_CTRL_WMASK) == 32'h0) else $error("control spare bits set");
  a_valid_one_pulse: assert property (sample_valid |=> !sample_valid)
    else $error("valid held too long");
  a_samples_hold: assert property ($changed(samples) |-> sample_valid)
    else $error("samples moved without valid");
  a_slot_full_width: assert property (sample_valid |-> quiet_reg >= 8'h1F)
    else $error("frame delivered before a full slot");

  c_frame: cover property (sample_valid);
  c_write: cover property (wb_ack_o && $past(wb_we_i));
  c_read: cover property (wb_ack_o && !$past(wb_we_i));
endmodule

bind tsr_router tsr_router_props u_tsr_router_props (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk(link_clk),
  .frame_sync(frame_sync), .samples(samples), .sample_valid(sample_valid));
`default_nettype wire

// ### bench/tsr_host_model.sv
// Host model: sends TDM, left-justified and I2S frames on the serial link.
// Assumes a free bit clock from the bench; lines flip before and after each frame.
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
  input wire logic link_clk,
  output logic frame_sync,
  output logic first_serial_input,
  output logic second_serial_input
);
  initial begin
    frame_sync = 1'b0;
    first_serial_input = 1'b0;
    second_serial_input = 1'b0;
  end

  // Sync settles at its idle level, I2S falls one edge early, bit 31 leads each slot
  task automatic send(input int n, input logic i2s, input logic [15:0][31:0] a,
    input logic [15:0][31:0] b);
    for (int i = -40; i <= n * 32; i++) begin
      @(posedge link_clk);
      frame_sync <= i < -1 ? i2s : (i2s ? i >= 31 : i >= 0 && i < 32);
      if (i >= 0 && i < n * 32) begin
        first_serial_input <= a[i / 32][31 - i % 32];
        second_serial_input <= b[i / 32][31 - i % 32];
      end else begin
        first_serial_input <= ~first_serial_input;
        second_serial_input <= ~second_serial_input;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### bench/tdm_slot_path_router_bench.sv
// Bench for the slot router: register access and routed TDM and stereo frames.
// Assumes the host model drives the link and the checker is bound beside it.
`timescale 1ns/1ps
`default_nettype none
`define chk(got, want) begin samples_checked++; if ((got) !== (want)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module tdm_slot_path_router_bench;
  import tsr_pkg::*;
  logic clk = 0, rst_n = 0, link_clk = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, q;
  logic wb_ack, frame_sync, line1, line2, sample_valid;
  tsr_frame_s samples;
  int bad_count = 0, samples_checked = 0, salt, p, l;
  logic [23:0] exp_trk, exp_ll [4];
  always #25 clk = ~clk;
  always #6 link_clk = ~link_clk;

  tsr_router u_tsr_router (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link_clk(link_clk), .frame_sync(frame_sync),
    .first_serial_input(line1), .second_serial_input(line2), .samples(samples),
    .sample_valid(sample_valid));
  tsr_host_model u_tsr_host_model (.link_clk(link_clk), .frame_sync(frame_sync),
    .first_serial_input(line1), .second_serial_input(line2));

  // Slot word: audio part unique per line and slot, low byte unique per frame
  function automatic logic [31:0] wd(input int ln, input int s);
    return {8'(ln * 64 + s * 3 + salt), 8'(s), 8'(ln), 8'(ln * 32 + s + salt)};
  endfunction
  function automatic logic [23:0] hi(input int ln, input int s);
    return 24'(wd(ln, s) >> 8);
  endfunction
  function automatic logic [7:0] lo(input int ln, input int s);
    return 8'(wd(ln, s));
  endfunction

  // One classic cycle; only the watchdog ends a wait on a dead slave
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Send a frame and wait for its delivery pulse
  task automatic frame(input int n, input logic i2s);
    logic [15:0][31:0] a, b;
    int k;
    for (int s = 0; s < 16; s++) begin
      a[s] = wd(0, s);
      b[s] = wd(1, s);
    end
    u_tsr_host_model.send(n, i2s, a, b);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (sample_valid !== 1'b1 && k < 400);
    if (k >= 400) bad_count++;
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Eleven frames, nine TDM of about 560 link edges and two stereo of about 105, plus bus cycles, with ample margin
  initial begin
    #400000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, TSR_OFS_DSEL, 0);
    `chk(q, TSR_DSEL_RST)
    wb(0, TSR_OFS_MASK, 0);
    `chk(q, TSR_MASK_RST)
    wb(0, 8'h20, 0);
    `chk(q, 32'h0)
    wb(1, TSR_OFS_DSEL, 32'hFFFFFFFF);
    wb(0, TSR_OFS_DSEL, 0);
    `chk(q, 32'h77)
    // Every code, main and low latency on opposite lines so no slot feeds both of them
    for (int c = 0; c < 8; c++) begin
      l = (c + 4) % 8;
      // Unmasked pair sits in slots that neither audio path uses this frame
      p = (c - 4) * 7 + 5;
      salt = c;
      wb(1, TSR_OFS_DSEL, 32'(l * 16 + c));
      wb(1, TSR_OFS_CTRL, 32'(16 + (c < 4 ? c : 4)));
      wb(1, TSR_OFS_MASK, c < 4 ? 32'hFFFFFFFF : ~(32'h3 << p));
      frame(16, 1'b0);
      for (int k = 0; k < 4; k++) begin
        exp_ll[k] = hi(l / 4, l % 4 * 4 + k);
        `chk(samples.main_audio_converters[k], hi(c / 4, c % 4 * 4 + k))
        `chk(samples.low_latency_path[k], exp_ll[k])
      end
      exp_trk = c < 4 ? {lo(0, c * 4), lo(0, c * 4 + 1), lo(0, c * 4 + 2)} : hi(p / 16, p % 16);
      `chk(samples.tracking_converter, exp_trk)
    end
    // Eight frames so far; the readback word is the last tracking sample
    wb(0, TSR_OFS_STAT, 0);
    `chk(q, 32'h0000_0008)
    wb(0, TSR_OFS_TRK, 0);
    `chk(q, {8'h00, exp_trk})
    // Mask mode with every slot masked admits nothing; reserved codes are never written
    wb(1, TSR_OFS_CTRL, 32'h14);
    wb(1, TSR_OFS_MASK, 32'hFFFF_FFFF);
    salt = 9;
    frame(16, 1'b0);
    `chk(samples.tracking_converter, exp_trk)
    for (int k = 0; k < 4; k++) begin
      exp_ll[k] = hi(0, 12 + k);
    end
    // Left-justified then I2S: fixed routing, selects ignored, other paths hold
    for (int m = 0; m < 2; m++) begin
      salt = 10 + m;
      // Tracking select parked at zero: its converter has no source in these formats
      wb(1, TSR_OFS_CTRL, 32'(m * 32));
      frame(2, 1'(m));
      for (int k = 0; k < 4; k++) begin
        `chk(samples.main_audio_converters[k], hi(k / 2, k % 2))
        `chk(samples.low_latency_path[k], exp_ll[k])
      end
      `chk(samples.tracking_converter, exp_trk)
    end
    conclude();
  end
endmodule
`default_nettype wire
